// [design/wcc_regs.svh]
// Offsets, field positions and reset values of the wetting current configuration registers.
// Assumes a 6-bit register index and 24-bit register words from the serial front end.
`ifndef WCC_REGS_SVH
`define WCC_REGS_SVH

`define WCC_ADDR_W        6
`define WCC_DATA_W        24
`define WCC_DIR_OFS       6'h1c
`define WCC_LVL_OFS       6'h1d
`define WCC_DIR_RST       10'h000
`define WCC_LVL_RST       24'h000000
`define WCC_DIR_BITS      10
`define WCC_LVL_INPUTS    12
`define WCC_LVL_CODE_W    3
`define WCC_LSB_PAIR_0_1  0
`define WCC_LSB_PAIR_2_3  3
`define WCC_LSB_INPUT4    6
`define WCC_LSB_INPUT5    9
`define WCC_LSB_PAIR_6_7  12
`define WCC_LSB_PAIR_8_9  15
`define WCC_LSB_INPUT10   18
`define WCC_LSB_INPUT11   21

`endif

// [design/wcc_pkg.sv]
// Types shared by the wetting current configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
package wcc_pkg;

    // Normalised wetting current level handed to the analog current sources
    typedef enum logic [2:0] {
        WCC_LVL_OFF  = 3'h0,
        WCC_LVL_1MA  = 3'h1,
        WCC_LVL_2MA  = 3'h2,
        WCC_LVL_5MA  = 3'h3,
        WCC_LVL_10MA = 3'h4,
        WCC_LVL_15MA = 3'h5
    } wcc_level_t;

endpackage

// [design/wcc_config_regs.sv]
// Wetting current direction register for inputs 0 to 9 and level register for inputs 0 to 11.
// Assumes the serial front end and the input enable register run on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "wcc_regs.svh"

module wcc_config_regs
    import wcc_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        srst_i,
    input  wire logic        wr_en_i,
    input  wire logic        rd_en_i,
    input  wire logic [5:0]  addr_i,
    input  wire logic [23:0] wdata_i,
    input  wire logic [11:0] input_enable_i,
    output logic      [23:0] rdata_o,
    output logic             rvalid_o,
    output logic      [9:0]  sourcing_mode_o,
    output logic      [35:0] wetting_level_o
);

    // Bit position of the level field that serves a given input
    function automatic logic [4:0] field_lsb(input int unsigned idx);
        case (idx)
            0, 1:    field_lsb = 5'(`WCC_LSB_PAIR_0_1);
            2, 3:    field_lsb = 5'(`WCC_LSB_PAIR_2_3);
            4:       field_lsb = 5'(`WCC_LSB_INPUT4);
            5:       field_lsb = 5'(`WCC_LSB_INPUT5);
            6, 7:    field_lsb = 5'(`WCC_LSB_PAIR_6_7);
            8, 9:    field_lsb = 5'(`WCC_LSB_PAIR_8_9);
            10:      field_lsb = 5'(`WCC_LSB_INPUT10);
            default: field_lsb = 5'(`WCC_LSB_INPUT11);
        endcase
    endfunction

    // Raw code to level; the three top codes collapse onto the strongest setting
    function automatic wcc_level_t decode_level(input logic [2:0] code);
        case (code)
            3'h0:    decode_level = WCC_LVL_OFF;
            3'h1:    decode_level = WCC_LVL_1MA;
            3'h2:    decode_level = WCC_LVL_2MA;
            3'h3:    decode_level = WCC_LVL_5MA;
            3'h4:    decode_level = WCC_LVL_10MA;
            default: decode_level = WCC_LVL_15MA;
        endcase
    endfunction

    logic [9:0]  dir_r;
    logic [9:0]  dir_nxt;
    logic [23:0] lvl_r;
    logic [23:0] lvl_nxt;
    logic [23:0] rdata_r;
    logic [23:0] rdata_nxt;
    logic        rvalid_r;
    logic        rvalid_nxt;
    logic [9:0]  src_r;
    logic [9:0]  src_nxt;
    logic [35:0] wl_r;
    logic [35:0] wl_nxt;

    // Register writes
    always_comb begin
        dir_nxt = dir_r;
        lvl_nxt = lvl_r;
        if (wr_en_i && addr_i == `WCC_DIR_OFS) begin
            dir_nxt = wdata_i[9:0];
        end
        if (wr_en_i && addr_i == `WCC_LVL_OFS) begin
            lvl_nxt = wdata_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            dir_r <= `WCC_DIR_RST;
            lvl_r <= `WCC_LVL_RST;
        end else begin
            dir_r <= dir_nxt;
            lvl_r <= lvl_nxt;
        end
    end

    // Read port; unmapped offsets read zero so other banks can be OR-ed in
    always_comb begin
        rdata_nxt  = rdata_r;
        rvalid_nxt = rd_en_i;
        if (rd_en_i) begin
            case (addr_i)
                `WCC_DIR_OFS: rdata_nxt = {14'h0000, dir_r};
                `WCC_LVL_OFS: rdata_nxt = lvl_r;
                default:      rdata_nxt = 24'h000000;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rdata_r  <= 24'h000000;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // Drive to the current sources; disabled inputs are forced off so polling skips them
    always_comb begin
        src_nxt = ~dir_r;
        wl_nxt  = 36'h000000000;
        for (int i = 0; i < `WCC_LVL_INPUTS; i++) begin
            if (input_enable_i[i]) begin
                wl_nxt[3*i +: 3] = decode_level(lvl_r[field_lsb(i) +: 3]);
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            src_r <= 10'h3ff;
            wl_r  <= 36'h000000000;
        end else begin
            src_r <= src_nxt;
            wl_r  <= wl_nxt;
        end
    end

    assign rdata_o         = rdata_r;
    assign rvalid_o        = rvalid_r;
    assign sourcing_mode_o = src_r;
    assign wetting_level_o = wl_r;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);

    a_dir_after_reset: assert property (
        $fell(srst_i) |-> dir_r == 10'h000 && sourcing_mode_o == 10'h3ff)
        else $error("direction not cleared by reset");

    a_lvl_after_reset: assert property (
        $fell(srst_i) |-> lvl_r == 24'h000000 && wetting_level_o == 36'h000000000)
        else $error("level not cleared by reset");

    a_dir_write_src: assert property (
        wr_en_i && addr_i == 6'h1c && !wdata_i[0] ##1 !(wr_en_i && addr_i == 6'h1c)
        |=> sourcing_mode_o[0])
        else $error("cleared direction bit does not source");

    a_dir_write_sink: assert property (
        wr_en_i && addr_i == 6'h1c && wdata_i[9] ##1 !(wr_en_i && addr_i == 6'h1c)
        |=> !sourcing_mode_o[9])
        else $error("set direction bit does not sink");

    a_dir_rsv_read: assert property (
        rd_en_i && addr_i == 6'h1c |=> rvalid_o && rdata_o[23:10] == 14'h0000)
        else $error("reserved direction bits read nonzero");

    a_lvl_code_map: assert property (
        input_enable_i[5] && lvl_r[11:9] < 3'h5 |=> wetting_level_o[17:15] == $past(lvl_r[11:9]))
        else $error("level code mapped wrongly");

    a_lvl_saturate: assert property (
        input_enable_i[10] && lvl_r[20:18] >= 3'h5 |=> wetting_level_o[32:30] == 3'h5)
        else $error("high level code not saturated");

    a_pair_shared: assert property (
        input_enable_i[8] && input_enable_i[9] |=> wetting_level_o[26:24] == wetting_level_o[29:27])
        else $error("paired inputs differ");

    a_own_field: assert property (
        input_enable_i[11] && lvl_r[23:21] == 3'h3 && lvl_r[20:18] == 3'h1
        |=> wetting_level_o[35:33] == 3'h3 && wetting_level_o[32:30] == 3'h1)
        else $error("individual field misplaced");

    a_disabled_off: assert property (
        !input_enable_i[4] |=> wetting_level_o[14:12] == 3'h0)
        else $error("disabled input carries current");

    a_read_back: assert property (
        wr_en_i && addr_i == 6'h1d ##1 !wr_en_i ##1 rd_en_i && addr_i == 6'h1d && !wr_en_i
        |=> rdata_o == $past(wdata_i, 3))
        else $error("level register read back wrong");

    a_rvalid_pulse: assert property (
        !rd_en_i |=> !rvalid_o)
        else $error("read valid without a read strobe");

    a_rsv_write_drop: assert property (
        wr_en_i && addr_i == 6'h1c |=> dir_r == $past(wdata_i[9:0]))
        else $error("direction write not taken from the low bits");

    a_dir_hold: assert property (
        !(wr_en_i && addr_i == 6'h1c) |=> $stable(dir_r))
        else $error("direction register changed without a write");

    a_lvl_hold: assert property (
        !(wr_en_i && addr_i == 6'h1d) |=> $stable(lvl_r))
        else $error("level register changed without a write");

    a_unmapped_zero: assert property (
        rd_en_i && addr_i != 6'h1c && addr_i != 6'h1d |=> rdata_o == 24'h000000)
        else $error("unmapped read returned data");

    c_sink_selected: cover property (wr_en_i && addr_i == 6'h1c && wdata_i[9:0] == 10'h3ff);
    c_full_current:  cover property (wetting_level_o[2:0] == 3'h5);
    c_read_unmapped: cover property (rd_en_i && addr_i == 6'h00);
    c_own_fields:    cover property (lvl_r[23:21] == 3'h3 && lvl_r[20:18] == 3'h1);
    c_reset_release: cover property ($fell(srst_i));

endmodule // wcc_config_regs

`default_nettype wire

// [tb/wcc_host_model.sv]
// Host side model: issues single register writes and reads on the strobe bus.
// Assumes the block answers each read with rvalid_o one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none

module wcc_host_model (
    input  wire logic        clock_i,
    input  wire logic [23:0] rdata_i,
    input  wire logic        rvalid_i,
    output logic             wr_en_o,
    output logic             rd_en_o,
    output logic      [5:0]  addr_o,
    output logic      [23:0] wdata_o
);
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o  = 6'h00;
        wdata_o = 24'h000000;
    end

    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        @(posedge clock_i);
        #5;
        addr_o  = a;
        wdata_o = d;
        wr_en_o = 1'b1;
        @(posedge clock_i);
        #5;
        wr_en_o = 1'b0;
        // Released data shows the inverse so a stale word never looks fresh
        wdata_o = ~d;
    endtask

    task automatic rd(input logic [5:0] a, output logic [23:0] d);
        @(posedge clock_i);
        #5;
        addr_o  = a;
        rd_en_o = 1'b1;
        @(posedge clock_i);
        #5;
        rd_en_o = 1'b0;
        d = 'x;
        if (rvalid_i === 1'b1) d = rdata_i;
        addr_o = ~a;
    endtask
endmodule // wcc_host_model

`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the wetting current configuration registers.
// Assumes the host model in wcc_host_model.sv drives the register strobes.
`timescale 1ns/1ps
`default_nettype none

module tb;
    typedef struct {logic [5:0] a; logic [23:0] d; logic [11:0] en; logic [23:0] rb;} wcc_row_t;
    logic        clock_i, srst_i, wr_en, rd_en, rvalid;
    logic [5:0]  addr;
    logic [23:0] wdata, rdata, rv, lvl_v;
    logic [11:0] en;
    logic [9:0]  src, dir_v;
    logic [35:0] lvl;
    int          err_count, compares, cyc;
    wcc_row_t    rows[5] = '{'{6'h1c, 24'hffffff, 12'hfff, 24'h0003ff},
                             '{6'h1c, 24'hfc02aa, 12'hfff, 24'h0002aa},
                             '{6'h1d, 24'hfac688, 12'hfff, 24'hfac688},
                             '{6'h1d, 24'h053977, 12'h5a5, 24'h053977},
                             '{6'h1d, 24'h64c688, 12'hfff, 24'h64c688}};

    wcc_config_regs wcc_config_regs_i (.clock_i(clock_i), .srst_i(srst_i), .wr_en_i(wr_en), .rd_en_i(rd_en),
        .addr_i(addr), .wdata_i(wdata), .input_enable_i(en), .rdata_o(rdata), .rvalid_o(rvalid),
        .sourcing_mode_o(src), .wetting_level_o(lvl));
    wcc_host_model wcc_host_model_i (.clock_i(clock_i), .rdata_i(rdata), .rvalid_i(rvalid), .wr_en_o(wr_en),
        .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata));

    function automatic logic [35:0] exp_lvl(input logic [23:0] r, input logic [11:0] e);
        int lsb[12] = '{0, 0, 3, 3, 6, 9, 12, 12, 15, 15, 18, 21};
        logic [2:0] c;
        exp_lvl = '0;
        for (int i = 0; i < 12; i++) begin
            c = r[lsb[i]+:3];
            exp_lvl[3*i+:3] = e[i] ? ((c > 3'h5) ? 3'h5 : c) : 3'h0;
        end
    endfunction

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chk_out();
        check({26'h0, src}, {26'h0, ~dir_v});
        check(lvl, exp_lvl(lvl_v, en));
    endtask

    task automatic finish_test();
        $display("Counts: %0d compares, %0d mismatches", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic reset_check(input int n);
        srst_i = 1'b1;
        repeat (n) @(posedge clock_i);
        #5;
        srst_i = 1'b0;
        dir_v = 10'h000;
        lvl_v = 24'h000000;
        wcc_host_model_i.rd(6'h1c, rv);
        check({12'h0, rv}, 36'h0);
        wcc_host_model_i.rd(6'h1d, rv);
        check({12'h0, rv}, 36'h0);
        chk_out();
        $display("Reset test done at %0t", $time);
    endtask

    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            finish_test();
        end
    end

    initial begin
        en = 12'hfff;
        reset_check(16);
        foreach (rows[k]) begin
            en = rows[k].en;
            wcc_host_model_i.wr(rows[k].a, rows[k].d);
            wcc_host_model_i.rd(rows[k].a, rv);
            check({12'h0, rv}, {12'h0, rows[k].rb});
            if (rows[k].a == 6'h1c) dir_v = rows[k].rb[9:0];
            else lvl_v = rows[k].rb;
            chk_out();
            $display("Row %0d done at %0t", k, $time);
        end
        wcc_host_model_i.wr(6'h1e, 24'hffffff);
        wcc_host_model_i.rd(6'h1e, rv);
        check({12'h0, rv}, 36'h0);
        wcc_host_model_i.rd(6'h1c, rv);
        check({12'h0, rv}, 36'h0000002aa);
        @(posedge clock_i);
        #5;
        check({35'h0, rvalid}, 36'h0);
        wcc_host_model_i.rd(6'h1d, rv);
        check({12'h0, rv}, 36'h00064c688);
        en = 12'h000;
        repeat (2) @(posedge clock_i);
        #5;
        chk_out();
        $display("Unmapped and disable test done at %0t", $time);
        reset_check(2);
        finish_test();
    end
endmodule // tb

`default_nettype wire
